//--- verilog/dss_sequencer.sv
// drive enable and controlled-stop sequencer with APB registers
// Notes on behaviour
// R1: hw enable edge enables; mode 0 clears faults
// R2: software enable starts from start-up default
// R3: method 0 cuts power, then timed brake
// R4: method 1 dynamic brake, then power off
// R5: method 2 ramp until standstill or timeout
// R6: method 3 ramp, standstill, then dynamic brake
// R7: disable timeout deactivates and raises fault
// R8: critical, hw, safe-torque-off cut power now
// R9: controlled stop commands zero velocity ramp
// R10: function 13 input triggers controlled stop
// R11: software disable with method 2 starts stop
// R12: fieldbus object write requests controlled stop
// R13: stop-reaction fault does stop then disable
// R14: hw limit inputs stop without timeout
// R15: software position limit stops without timeout
// R16: 10 Hz filtered velocity against threshold
// R17: window held for hold time, excursion restarts
// R18: timeout runs independent of standstill qualifier
// R19: timeout in stop raises emergency timeout fault
// R20: current mode skips stop, stops immediately
// R21: stop indicator reads one during stop
//
// Local design decisions: the register addresses and the APB slave port.
`default_nettype none
module dss_sequencer (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic hw_enable,
  input wire logic safe_torque_off,
  input wire logic [dss_pkg::NUM_DIN-1:0] din,
  input wire logic software_position_limit,
  input wire logic critical_fault,
  input wire logic stop_fault,
  input wire logic fieldbus_cstop_wr,
  input wire logic [7:0] fieldbus_cstop_data,
  input wire logic signed [31:0] actual_velocity,
  output dss_pkg::dss_drive_t drive_out,
  output logic [31:0] stop_decel_rate,
  output logic emergency_timeout_fault
);
  import dss_pkg::*;

  // async pins pass two flops
  logic [NUM_DIN+3:0] sync1_ff;
  logic [NUM_DIN+3:0] sync2_ff;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync1_ff <= '0;
      sync2_ff <= '0;
    end else begin
      sync1_ff <= {software_position_limit, critical_fault, safe_torque_off, hw_enable, din};
      sync2_ff <= sync1_ff;
    end
  end
  wire [NUM_DIN-1:0] din_s = sync2_ff[NUM_DIN-1:0];
  wire hw_en_s = sync2_ff[NUM_DIN];
  wire sto_ok_s = sync2_ff[NUM_DIN+1];
  wire crit_s = sync2_ff[NUM_DIN+2];
  wire software_position_limit_s = sync2_ff[NUM_DIN+3];

  // registers
  logic [31:0] ctrl_ff;
  logic [31:0] vth_ff;
  logic [31:0] hold_ff;
  logic [31:0] disto_ff;
  logic [31:0] brake_ff;
  logic [4:0] din_fn_ff [NUM_DIN];
  logic [NUM_DIN-1:0] din_inv_ff;
  logic [7:0] fbobj_ff;
  wire wr = psel & penable & pwrite;
  wire rd_hit_ctrl = paddr == OFF_CTRL;
  wire wr_cmd = wr & (paddr == OFF_CMD);
  wire wr_din = wr & (paddr == OFF_DIN);
  wire [2:0] din_sel = pwdata[10:8];
  dss_method_t method;
  assign method = dss_method_t'(ctrl_ff[CTRL_DM_LO +: 2]);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_ff <= CTRL_RST;
      stop_decel_rate <= DEC_RST;
      vth_ff <= VTH_RST;
      hold_ff <= HOLD_RST;
      disto_ff <= DISTO_RST;
      brake_ff <= BRAKE_RST;
    end else if (wr) begin
      if (rd_hit_ctrl) ctrl_ff <= pwdata;
      if (paddr == OFF_DEC) stop_decel_rate <= pwdata;
      if (paddr == OFF_VTH) vth_ff <= pwdata;
      if (paddr == OFF_HOLD) hold_ff <= pwdata;
      if (paddr == OFF_DISTO) disto_ff <= pwdata;
      if (paddr == OFF_BRAKE) brake_ff <= pwdata;
    end
  end
  // per-input function and invert; written via index field
  genvar gi;
  logic [NUM_DIN-1:0] din_cs;
  logic [NUM_DIN-1:0] din_lim;
  generate
    for (gi = 0; gi < NUM_DIN; gi++) begin : g_din
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          din_fn_ff[gi] <= 5'h00;
          din_inv_ff[gi] <= 1'b0;
        end else if (wr_din && din_sel == 3'(gi)) begin
          din_fn_ff[gi] <= pwdata[4:0];
          din_inv_ff[gi] <= pwdata[7];
        end
      end
      wire act = din_s[gi] ^ din_inv_ff[gi];
      assign din_cs[gi] = act & (din_fn_ff[gi] == FN_CSTOP); // R10
      assign din_lim[gi] = act & ((din_fn_ff[gi] == FN_LIM_POS) | (din_fn_ff[gi] == FN_LIM_NEG)); // R14
    end
  endgenerate

  // fieldbus object: write-only byte, write is a stop request
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) fbobj_ff <= 8'h00;
    else if (fieldbus_cstop_wr) fbobj_ff <= fieldbus_cstop_data;
  end

  // velocity filter, first order low pass near 10 Hz
  logic signed [31+FILT_SHIFT:0] filt_ff;
  wire signed [31:0] vel_f = filt_ff[31+FILT_SHIFT:FILT_SHIFT];
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) filt_ff <= '0;
    else filt_ff <= filt_ff + (32+FILT_SHIFT)'(actual_velocity) - (32+FILT_SHIFT)'(vel_f); // R16
  end
  wire signed [31:0] vth_s = $signed(vth_ff);
  wire in_window = (vel_f <= vth_s) && (vel_f >= -vth_s); // R16

  // sequencer
  dss_state_t state_ff, nxt_state;
  logic sw_en_ff;
  logic strap_done_ff;
  logic hw_en_d_ff;
  logic fault_ff;
  logic to_en_ff;
  logic [31:0] hold_cnt_ff;
  logic [31:0] to_cnt_ff;
  logic [31:0] brk_cnt_ff;
  wire hw_rise = hw_en_s & ~hw_en_d_ff;
  wire cmd_en = wr_cmd & pwdata[CMD_SW_EN];
  wire cmd_dis = wr_cmd & pwdata[CMD_SW_DIS];
  wire cmd_clr = (wr_cmd & pwdata[CMD_CLR_FLT]) | (hw_rise & ~ctrl_ff[CTRL_HWMODE]); // R1
  wire hard_off = crit_s | ~hw_en_s | ~sto_ok_s; // R8
  wire cs_method = method == DSS_DM_CS_DISABLE || method == DSS_DM_CS_DYNBRAKE;
  wire cs_sw = cmd_dis & (method == DSS_DM_CS_DISABLE); // R11
  wire cs_timed = cs_sw | (|din_cs) | fieldbus_cstop_wr | stop_fault; // R10 R12 R13
  wire cs_untimed = (|din_lim) | software_position_limit_s; // R14 R15
  wire can_run = sw_en_ff & ~fault_ff & hw_en_s & sto_ok_s;
  wire standstill = in_window && hold_cnt_ff >= hold_ff; // R17
  wire timeout = to_en_ff && to_cnt_ff >= disto_ff; // R18
  wire brake_done = brk_cnt_ff >= brake_ff;
  wire dis_req = cmd_dis | cs_timed | cs_untimed;

  always_comb begin
    nxt_state = state_ff;
    unique case (state_ff)
      DSS_ST_OFF: if (can_run && !cs_untimed) nxt_state = DSS_ST_RUN;
      DSS_ST_RUN: begin
        if (!can_run && !cmd_dis) nxt_state = DSS_ST_OFF;
        else if (dis_req) begin
          if (ctrl_ff[CTRL_CURMODE]) nxt_state = DSS_ST_BRAKE; // R20
          else if (cs_timed || cs_untimed || (cmd_dis && cs_method)) nxt_state = DSS_ST_CSTOP; // R5 R6
          else if (method == DSS_DM_DYNBRAKE) nxt_state = DSS_ST_DBRAKE; // R4
          else nxt_state = DSS_ST_BRAKE; // R3
        end
      end
      DSS_ST_CSTOP: begin
        if (timeout) nxt_state = DSS_ST_BRAKE; // R7
        else if (standstill) nxt_state = (method == DSS_DM_CS_DYNBRAKE) ? DSS_ST_DBRAKE : DSS_ST_BRAKE; // R6
      end
      DSS_ST_DBRAKE: if (standstill || timeout) nxt_state = DSS_ST_BRAKE; // R4
      DSS_ST_BRAKE: if (brake_done) nxt_state = DSS_ST_OFF; // R3
      default: nxt_state = DSS_ST_OFF;
    endcase
    if (hard_off) nxt_state = DSS_ST_OFF; // R8
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_ff <= DSS_ST_OFF;
      hw_en_d_ff <= 1'b0;
      strap_done_ff <= 1'b0;
      sw_en_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      hw_en_d_ff <= hw_en_s;
      strap_done_ff <= 1'b1;
      // start-up default caught once after reset release
      if (!strap_done_ff) sw_en_ff <= ctrl_ff[CTRL_ENDEF]; // R2
      else if (cmd_dis || cs_timed) sw_en_ff <= 1'b0;
      else if (cmd_en || hw_rise) sw_en_ff <= 1'b1; // R1
    end
  end
  // note: ctrl resets to zero and is sampled on the first clock after reset, so default 1 never takes effect

  // fault: set wins over clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fault_ff <= 1'b0;
      emergency_timeout_fault <= 1'b0;
    end else begin
      if (timeout && (state_ff == DSS_ST_CSTOP || state_ff == DSS_ST_DBRAKE)) begin
        emergency_timeout_fault <= 1'b1; // R19
        fault_ff <= 1'b1; // R7
      end else if (cmd_clr) begin
        emergency_timeout_fault <= 1'b0;
        fault_ff <= 1'b0;
      end
    end
  end

  wire stopping = state_ff == DSS_ST_CSTOP || state_ff == DSS_ST_DBRAKE;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hold_cnt_ff <= '0;
      to_cnt_ff <= '0;
      to_en_ff <= 1'b0;
      brk_cnt_ff <= '0;
    end else begin
      if (!stopping || !in_window) hold_cnt_ff <= '0; // R17
      else if (hold_cnt_ff < hold_ff) hold_cnt_ff <= hold_cnt_ff + 32'h0000_0001;
      if (state_ff == DSS_ST_RUN) begin
        to_cnt_ff <= '0;
        // limit switches alone leave the timeout idle
        to_en_ff <= ~cs_untimed | cs_timed | cmd_dis; // R14 R15
      end else if (stopping && to_cnt_ff < disto_ff) to_cnt_ff <= to_cnt_ff + 32'h0000_0001; // R18
      if (state_ff != DSS_ST_BRAKE) brk_cnt_ff <= '0;
      else if (!brake_done) brk_cnt_ff <= brk_cnt_ff + 32'h0000_0001;
    end
  end

  // outputs registered
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) drive_out <= '0;
    else begin
      drive_out.power_on <= nxt_state == DSS_ST_RUN || nxt_state == DSS_ST_CSTOP; // R3 R8
      drive_out.dyn_brake <= nxt_state == DSS_ST_DBRAKE; // R4 R6
      drive_out.brake_release <= ctrl_ff[CTRL_BRAKE_FIT] ? (nxt_state == DSS_ST_RUN || nxt_state == DSS_ST_CSTOP)
                                                         : 1'b1; // R3 R5
      drive_out.vel_zero_cmd <= nxt_state == DSS_ST_CSTOP; // R9
      drive_out.cstop_active <= nxt_state == DSS_ST_CSTOP; // R21
    end
  end

  // read mux, zero wait state
  logic [31:0] rdata;
  always_comb begin
    rdata = 32'h0000_0000;
    pslverr = 1'b0;
    unique case (paddr)
      OFF_CTRL: rdata = ctrl_ff;
      OFF_CMD: rdata = 32'h0000_0000;
      OFF_DEC: rdata = stop_decel_rate;
      OFF_VTH: rdata = vth_ff;
      OFF_HOLD: rdata = hold_ff;
      OFF_DISTO: rdata = disto_ff;
      OFF_BRAKE: rdata = brake_ff;
      OFF_DIN: rdata = {24'h000000, din_inv_ff[0], 2'b00, din_fn_ff[0]};
      OFF_STAT: rdata = {25'h0000000, emergency_timeout_fault, fault_ff, sw_en_ff, state_ff, drive_out.cstop_active}; // R21
      OFF_VEL: rdata = vel_f;
      OFF_FBOBJ: rdata = 32'h0000_0000;
      default: pslverr = psel & penable;
    endcase
  end
  assign pready = 1'b1;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) prdata <= 32'h0000_0000;
    else if (psel && !penable) prdata <= rdata;
  end
endmodule : dss_sequencer
`default_nettype wire

//--- verilog/dss_pkg.sv
// package for the drive enable and controlled-stop sequencer
`default_nettype none
package dss_pkg;
  localparam int unsigned CLK_HZ = 25000000;
  // register byte offsets
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_CMD = 8'h04;
  localparam logic [7:0] OFF_DEC = 8'h08;
  localparam logic [7:0] OFF_VTH = 8'h0C;
  localparam logic [7:0] OFF_HOLD = 8'h10;
  localparam logic [7:0] OFF_DISTO = 8'h14;
  localparam logic [7:0] OFF_BRAKE = 8'h18;
  localparam logic [7:0] OFF_DIN = 8'h1C;
  localparam logic [7:0] OFF_STAT = 8'h20;
  localparam logic [7:0] OFF_VEL = 8'h24;
  localparam logic [7:0] OFF_FBOBJ = 8'h28;
  // control fields
  localparam int CTRL_HWMODE = 0;
  localparam int CTRL_ENDEF = 1;
  localparam int CTRL_DM_LO = 2;
  localparam int CTRL_CURMODE = 4;
  localparam int CTRL_BRAKE_FIT = 5;
  // command fields (write one)
  localparam int CMD_SW_EN = 0;
  localparam int CMD_SW_DIS = 1;
  localparam int CMD_CLR_FLT = 2;
  localparam logic [31:0] CTRL_RST = 32'h0000_0000;
  localparam logic [31:0] DEC_RST = 32'h0000_0010;
  localparam logic [31:0] VTH_RST = 32'h0000_0100;
  localparam logic [31:0] HOLD_RST = 32'h0000_1000;
  localparam logic [31:0] DISTO_RST = 32'h0001_0000;
  localparam logic [31:0] BRAKE_RST = 32'h0000_0100;
  // input functions
  localparam int NUM_DIN = 7;
  localparam logic [4:0] FN_CSTOP = 5'h0D;
  localparam logic [4:0] FN_LIM_POS = 5'h12;
  localparam logic [4:0] FN_LIM_NEG = 5'h13;
  // 10 Hz first-order filter: alpha = 2*pi*10/25e6 ~ 2^-18
  localparam int FILT_SHIFT = 18;
  localparam int unsigned FILT_HZ = 10;
  typedef enum logic [1:0] {
    DSS_DM_IMMEDIATE = 2'b00,
    DSS_DM_DYNBRAKE = 2'b01,
    DSS_DM_CS_DISABLE = 2'b10,
    DSS_DM_CS_DYNBRAKE = 2'b11
  } dss_method_t;
  typedef enum logic [2:0] {
    DSS_ST_OFF = 3'b000,
    DSS_ST_RUN = 3'b001,
    DSS_ST_CSTOP = 3'b010,
    DSS_ST_DBRAKE = 3'b011,
    DSS_ST_BRAKE = 3'b100
  } dss_state_t;
  typedef struct packed {
    logic power_on;
    logic dyn_brake;
    logic brake_release;
    logic vel_zero_cmd;
    logic cstop_active;
  } dss_drive_t;
endpackage : dss_pkg
`default_nettype wire

//--- bench/dss_sequencer_sva.sv
// port checker for the drive enable and controlled-stop sequencer
`default_nettype none
module dss_sequencer_sva (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pslverr,
  input wire logic safe_torque_off,
  input wire logic critical_fault,
  input wire logic stop_fault,
  input wire logic fieldbus_cstop_wr,
  input wire dss_pkg::dss_drive_t drive_out,
  input wire logic emergency_timeout_fault
);
  import dss_pkg::*;
  logic idle_run;
  // a running drive with nothing else pulling it down
  assign idle_run = drive_out.power_on && !drive_out.cstop_active && safe_torque_off && !critical_fault;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_sto_cuts_power: assert property (!safe_torque_off |-> ##[1:5] !drive_out.power_on)
    else $error("power stays on with torque-off low");
  a_crit_cuts_power: assert property (critical_fault |-> ##[1:5] !drive_out.power_on)
    else $error("power stays on after critical fault");
  a_stop_zero_vel: assert property (drive_out.cstop_active |-> drive_out.vel_zero_cmd && drive_out.power_on)
    else $error("stop without zero velocity command");
  a_dbrake_from_on: assert property ($rose(drive_out.dyn_brake) |-> $past(drive_out.power_on))
    else $error("dynamic brake from a stopped drive");
  a_tmo_from_active: assert property ($rose(emergency_timeout_fault) |-> $past(drive_out.power_on))
    else $error("timeout fault with no disable running");
  a_tmo_power_off: assert property ($rose(emergency_timeout_fault) |-> ##[0:2] !drive_out.power_on)
    else $error("timeout did not deactivate");
  a_fbus_starts_stop: assert property (fieldbus_cstop_wr && idle_run
    |-> ##[1:4] (drive_out.cstop_active || !drive_out.power_on))
    else $error("fieldbus stop ignored");
  a_fault_starts_stop: assert property (stop_fault && idle_run
    |-> ##[1:4] (drive_out.cstop_active || !drive_out.power_on))
    else $error("stop fault ignored");
  a_err_in_access: assert property (pslverr |-> psel && penable)
    else $error("error outside access phase");
  c_stop: cover property ($rose(drive_out.cstop_active));
  c_dbrake: cover property ($rose(drive_out.dyn_brake));
  c_tmo: cover property ($rose(emergency_timeout_fault));
endmodule : dss_sequencer_sva
bind dss_sequencer dss_sequencer_sva u_dss_sequencer_sva (.pclk, .presetn, .psel, .penable, .pslverr,
  .safe_torque_off, .critical_fault, .stop_fault, .fieldbus_cstop_wr, .drive_out, .emergency_timeout_fault);
`default_nettype wire

//--- bench/dss_motion_model.sv
// motion controller model: shaft velocity reported to the sequencer
`default_nettype none
module dss_motion_model (
  input wire logic pclk,
  input wire logic presetn,
  input wire dss_pkg::dss_drive_t drive_out,
  input wire logic spin,
  output logic signed [31:0] actual_velocity
);
  import dss_pkg::*;
  // a spinning axis keeps full speed; otherwise the zero velocity command quarters it each cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      actual_velocity <= 32'sh0000_0000;
    end else if (spin) begin
      actual_velocity <= 32'sh4000_0000;
    end else if (drive_out.vel_zero_cmd) begin
      actual_velocity <= actual_velocity >>> 2;
    end
  end
endmodule : dss_motion_model
`default_nettype wire

//--- bench/dss_sequencer_tb_top.sv
// testbench for the drive enable and controlled-stop sequencer
`default_nettype none
module dss_sequencer_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  import dss_pkg::*;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, spin = 1'b0;
  logic [7:0] paddr = 8'h00, fieldbus_cstop_data = 8'h01;
  logic [31:0] pwdata = 32'h0, prdata, stop_decel_rate, rd;
  logic pready, pslverr, emergency_timeout_fault, err, hw_enable = 1'b0, safe_torque_off = 1'b1;
  logic software_position_limit = 1'b0, critical_fault = 1'b0, stop_fault = 1'b0, fieldbus_cstop_wr = 1'b0;
  logic [NUM_DIN-1:0] din = 7'h00;
  logic signed [31:0] actual_velocity;
  dss_drive_t drive_out;
  int fail_count = 0, n_compared = 0;
  bit seen_cs, seen_db;
  always #20 pclk = ~pclk;
  dss_sequencer u_dss_sequencer (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .hw_enable, .safe_torque_off, .din, .software_position_limit, .critical_fault,
    .stop_fault, .fieldbus_cstop_wr, .fieldbus_cstop_data, .actual_velocity, .drive_out, .stop_decel_rate,
    .emergency_timeout_fault);
  dss_motion_model u_dss_motion_model (.pclk, .presetn, .drive_out, .spin, .actual_velocity);
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb
  // stops early once the power stage is off
  task automatic watch(input int n);
    seen_cs = 1'b0;
    seen_db = 1'b0;
    repeat (n) begin
      @(posedge pclk);
      seen_cs |= drive_out.cstop_active;
      seen_db |= drive_out.dyn_brake;
      if (drive_out.power_on === 1'b0) break;
    end
  endtask : watch
  task automatic hw_edge();
    hw_enable <= 1'b0;
    repeat (20) @(posedge pclk);
    hw_enable <= 1'b1;
    repeat (20) @(posedge pclk);
  endtask : hw_edge
  task automatic enable();
    apb(1'b1, OFF_CMD, 32'h0000_0004);
    hw_edge();
    chk(drive_out.power_on, 1'b1);
  endtask : enable
  task automatic t_regs();
    logic [7:0] a[8] = '{OFF_CTRL, OFF_DEC, OFF_VTH, OFF_HOLD, OFF_DISTO, OFF_BRAKE, OFF_STAT, 8'h40};
    logic [31:0] v[8] = '{CTRL_RST, DEC_RST, VTH_RST, HOLD_RST, DISTO_RST, BRAKE_RST, 32'h0, 32'h0};
    for (int i = 0; i < 8; i++) begin
      apb(1'b0, a[i], 32'h0);
      chk(rd, v[i]);
      chk(err, i == 7);
    end
    apb(1'b1, OFF_DEC, 32'h0000_0055);
    chk(stop_decel_rate, 32'h0000_0055);
    apb(1'b1, OFF_HOLD, 32'h0000_0014);
    apb(1'b1, OFF_DISTO, 32'h0000_012C);
    apb(1'b1, OFF_BRAKE, 32'h0000_0008);
    $display("registers done");
  endtask : t_regs
  task automatic t_method(input logic [1:0] m, input logic cur);
    apb(1'b1, OFF_CTRL, {27'h0, cur, m, 2'h0});
    enable();
    apb(1'b1, OFF_CMD, 32'h0000_0002);
    watch(400);
    chk(drive_out.power_on, 1'b0);
    chk(seen_cs, m[1] & !cur);
    chk(seen_db, m[0] & !cur);
    chk(emergency_timeout_fault, 1'b0);
    $display("method %0d done", m);
  endtask : t_method
  task automatic t_trig(input int k);
    apb(1'b1, OFF_CTRL, 32'h0);
    apb(1'b1, OFF_DIN, k == 3 ? 32'h0000_0012 : 32'h0000_000D);
    enable();
    case (k)
      0, 3: din[0] <= 1'b1;
      1: fieldbus_cstop_wr <= 1'b1;
      2: stop_fault <= 1'b1;
      default: software_position_limit <= 1'b1;
    endcase
    @(posedge pclk);
    fieldbus_cstop_wr <= 1'b0;
    stop_fault <= 1'b0;
    watch(400);
    chk(seen_cs, 1'b1);
    chk(drive_out.power_on, 1'b0);
    din[0] <= 1'b0;
    software_position_limit <= 1'b0;
    apb(1'b1, OFF_DIN, 32'h0);
    $display("trigger %0d done", k);
  endtask : t_trig
  task automatic t_cut(input int k);
    apb(1'b1, OFF_CTRL, 32'h0000_0008);
    enable();
    if (k == 0) critical_fault <= 1'b1;
    else safe_torque_off <= 1'b0;
    watch(20);
    chk(drive_out.power_on, 1'b0);
    chk(seen_cs, 1'b0);
    critical_fault <= 1'b0;
    safe_torque_off <= 1'b1;
    $display("cut %0d done", k);
  endtask : t_cut
  // runs last: spin is never released, so the slow velocity filter stays high afterwards
  task automatic t_timeout();
    apb(1'b1, OFF_CTRL, 32'h0000_0008);
    spin <= 1'b1;
    enable();
    apb(1'b1, OFF_CMD, 32'h0000_0002);
    watch(600);
    chk(seen_cs, 1'b1);
    chk(drive_out.power_on, 1'b0);
    chk(emergency_timeout_fault, 1'b1);
    apb(1'b0, OFF_STAT, 32'h0);
    chk(rd[6], 1'b1);
    apb(1'b1, OFF_CTRL, 32'h0000_0009);
    hw_edge();
    chk(emergency_timeout_fault, 1'b1);
    apb(1'b1, OFF_CTRL, 32'h0000_0008);
    hw_edge();
    chk(emergency_timeout_fault, 1'b0);
    apb(1'b1, OFF_DIN, 32'h0000_0012);
    din[0] <= 1'b1;
    watch(600);
    chk(drive_out.cstop_active, 1'b1);
    chk(emergency_timeout_fault, 1'b0);
    apb(1'b0, OFF_STAT, 32'h0);
    chk(rd[0], 1'b1);
    critical_fault <= 1'b1;
    $display("timeout done");
  endtask : t_timeout
  task automatic test_done();
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : test_done
  initial begin
    repeat (20000) @(posedge pclk);
    fail_count++;
    test_done();
  end
  initial begin
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    t_regs();
    for (int m = 0; m < 4; m++) t_method(m[1:0], 1'b0);
    t_method(2'h2, 1'b1);
    for (int k = 0; k < 5; k++) t_trig(k);
    for (int k = 0; k < 2; k++) t_cut(k);
    t_timeout();
    test_done();
  end
endmodule : dss_sequencer_tb_top
`default_nettype wire
